// ===== inc/hderr_consts.svh
// Behaviour
// - channelized port reports code 8 when receive out-of-frame input asserts.
// - frame closed by aligned flag with bad checksum reports code 9 in bits 19:16.
// - payload not a whole number of octets after zero removal reports code 10.
// - when code 10 is reported the same message never also reports code 9.
// - message ended by seven ones abort instead of flag reports code 11.
// - over-length message stops, is not transferred, and reports code 12.
// - message no longer than checksum bits is not transferred, reports code 13.
// - signalling mode reports code 14 when error count rises past threshold.
// - parity error in a receiving bus data phase reports code 15.
// - the bus system-error signal is ignored and raises nothing.
// - parity interrupt suppressed when parity error response bit is zero or mask bit 7 is zero.
// - descriptor bit 15 is the lost flag, one means conditions were dropped.
// - on queue overflow new descriptors drop and last queued gets lost flag.
// - setting the lost flag changes no other descriptor field.
// - error field zero means the descriptor carries no error.
`ifndef HDERR_CONSTS_SVH
`define HDERR_CONSTS_SVH
`define HDERR_ERR_LSB      16
`define HDERR_ERR_MSB      19
`define HDERR_LOST_BIT     15
`define HDERR_REG_STATUS   8'h00
`define HDERR_REG_MASK     8'h04
`define HDERR_REG_CTRL     8'h08
`define HDERR_REG_THRESH   8'h0C
`define HDERR_REG_QCOUNT   8'h10
`define HDERR_CTRL_MEM_PROTECT_VIOLATION    0
`define HDERR_CTRL_CHAN    1
`define HDERR_CTRL_SS7     2
`define HDERR_THRESH_RST   8'h40
`endif

// ===== inc/hderr_pkg.sv
package hderr_pkg;
	typedef enum logic [3:0] {
		HDERR_NONE  = 4'h0,
		HDERR_MEM_PROTECT_VIOLATION  = 4'h4,
		HDERR_OOF   = 4'h8,
		HDERR_CHK   = 4'h9,
		HDERR_ALIGN = 4'hA,
		HDERR_ABORT = 4'hB,
		HDERR_LONG  = 4'hC,
		HDERR_SHORT = 4'hD,
		HDERR_RATE  = 4'hE,
		HDERR_PAR   = 4'hF
	} hderr_code_t;
	typedef enum logic [0:0] {HDERR_IDLE, HDERR_SEND} hderr_state_t;
endpackage

// ===== src/hderr_report.sv
`timescale 1ns/10ps
`include "hderr_consts.svh"
module hderr_report #(
	parameter int DEPTH = 8,
	parameter int EVW   = 8
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rstn,
	// register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [31:0]        reg_rdata,
	output logic                    irq,
	// memory protection
	input  wire logic               dma_req,
	input  wire logic [31:0]        dma_addr,
	input  wire logic [31:0]        mem_protect_violation_lo,
	input  wire logic [31:0]        mem_protect_violation_hi,
	output logic                    dma_go,
	// receive frame status; out-of-frame is a level, the rest is sampled on the msg_end pulse
	input  wire logic               rx_frame_loss_input,
	input  wire logic               msg_end,
	input  wire logic               end_flag,
	input  wire logic               end_abort,
	input  wire logic               chk_bad,
	input  wire logic [2:0]         bit_rem,
	input  wire logic [14:0]        msg_bits,
	input  wire logic [14:0]        max_bits,
	input  wire logic               chk32,
	output logic                    rx_drop,
	// signalling monitor, parity
	input  wire logic [7:0]         signal_unit_error_count,
	input  wire logic               par_err_rx,
	input  wire logic               serr_n,
	input  wire logic               par_resp_en,
	// descriptor output to bus master
	output logic                    desc_valid,
	output logic      [31:0]        desc_data,
	input  wire logic               desc_ready
);
	// the event vector is laid out for eight status bits only
	generate
		if (DEPTH < 2 || DEPTH > 64 || EVW != 8) begin : g_bad_param
			$error("hderr_report: unsupported parameters");
		end
	endgenerate
	localparam int AW = $clog2(DEPTH);
	////////////////////////////////////////////////////////////////////
	logic [31:0] ctrl_r, thresh_r;
	logic [7:0]  stat_r, mask_r;
	logic [7:0]  ev;
	logic        mem_protect_violation_bad, rate_nxt, rate_prev_r, rx_bad_len;
	logic        oof_prev_r, oof_rise, rate_rise, hi_ev;
	logic [14:0] short_lim;
	hderr_pkg::hderr_code_t code;
	// serr_n is deliberately unused: system error raises nothing
	assign mem_protect_violation_bad = ctrl_r[`HDERR_CTRL_MEM_PROTECT_VIOLATION] && dma_req &&
		(dma_addr < mem_protect_violation_lo || dma_addr > mem_protect_violation_hi);
	assign rate_nxt = ctrl_r[`HDERR_CTRL_SS7] &&
		(signal_unit_error_count > thresh_r[7:0]);
	assign rate_rise = rate_nxt && !rate_prev_r;
	// out-of-frame is a level; only its assertion is an event, otherwise
	// a long loss of frame would flood the queue
	assign oof_rise = rx_frame_loss_input && !oof_prev_r;
	// short limit is the checksum width in bits
	assign short_lim = chk32 ? 15'h0020 : 15'h0010;
	assign hi_ev = (par_err_rx && par_resp_en) || mem_protect_violation_bad ||
		(oof_rise && ctrl_r[`HDERR_CTRL_CHAN]) || rate_rise;
	////////////////////////////////////////////////////////////////////
	// classify one event per cycle, most severe first
	always_comb begin
		code = hderr_pkg::HDERR_NONE;
		if (par_err_rx && par_resp_en)
			code = hderr_pkg::HDERR_PAR;
		else if (mem_protect_violation_bad)
			code = hderr_pkg::HDERR_MEM_PROTECT_VIOLATION;
		else if (oof_rise && ctrl_r[`HDERR_CTRL_CHAN])
			code = hderr_pkg::HDERR_OOF;
		else if (rate_rise)
			code = hderr_pkg::HDERR_RATE;
		else if (msg_end) begin
			if (msg_bits > max_bits)
				code = hderr_pkg::HDERR_LONG;
			else if (msg_bits <= short_lim)
				code = hderr_pkg::HDERR_SHORT;
			else if (end_abort)
				code = hderr_pkg::HDERR_ABORT;
			else if (bit_rem != 3'h0)
				code = hderr_pkg::HDERR_ALIGN;
			else if (end_flag && chk_bad)
				code = hderr_pkg::HDERR_CHK;
		end
	end
	assign rx_bad_len = msg_end && (msg_bits > max_bits ||
		msg_bits <= short_lim);
	// one status bit per event class, except long and short which share ev[3]
	assign ev[7] = code == hderr_pkg::HDERR_PAR;
	assign ev[6] = code == hderr_pkg::HDERR_MEM_PROTECT_VIOLATION;
	assign ev[5] = code == hderr_pkg::HDERR_OOF;
	assign ev[4] = code == hderr_pkg::HDERR_RATE;
	assign ev[3] = code == hderr_pkg::HDERR_LONG ||
		code == hderr_pkg::HDERR_SHORT;
	assign ev[2] = code == hderr_pkg::HDERR_ABORT;
	assign ev[1] = code == hderr_pkg::HDERR_ALIGN;
	assign ev[0] = code == hderr_pkg::HDERR_CHK;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dma_go <= 1'b0;
			rx_drop <= 1'b0;
			rate_prev_r <= 1'b0;
			oof_prev_r <= 1'b0;
		end else begin
			dma_go <= dma_req && !mem_protect_violation_bad;
			rx_drop <= rx_bad_len;
			rate_prev_r <= rate_nxt;
			// reset value matches the idle pin, so no false edge
			oof_prev_r <= rx_frame_loss_input;
		end
	end
	////////////////////////////////////////////////////////////////////
	// classification checks
	chk_oof_edge: assert property (@(posedge core_clk) disable iff (!rstn)
		rx_frame_loss_input && $past(rx_frame_loss_input)
		|-> code != hderr_pkg::HDERR_OOF)
		else $error("out of frame reported twice for one assertion");
	chk_oof_mode: assert property (@(posedge core_clk) disable iff (!rstn)
		!ctrl_r[`HDERR_CTRL_CHAN] |-> code != hderr_pkg::HDERR_OOF)
		else $error("out of frame reported outside channelized mode");
	chk_rate_mode: assert property (@(posedge core_clk) disable iff (!rstn)
		!ctrl_r[`HDERR_CTRL_SS7] |-> code != hderr_pkg::HDERR_RATE)
		else $error("rate alarm outside signalling mode");
	chk_mem_protect_violation_mode: assert property (@(posedge core_clk) disable iff (!rstn)
		!ctrl_r[`HDERR_CTRL_MEM_PROTECT_VIOLATION] |-> code != hderr_pkg::HDERR_MEM_PROTECT_VIOLATION)
		else $error("protection fault while protection off");
	chk_short_drop: assert property (@(posedge core_clk) disable iff (!rstn)
		msg_end && msg_bits <= short_lim |=> rx_drop)
		else $error("short message not dropped");
	chk_abort_code: assert property (@(posedge core_clk) disable iff (!rstn)
		msg_end && !hi_ev && msg_bits <= max_bits &&
		msg_bits > short_lim && end_abort
		|-> code == hderr_pkg::HDERR_ABORT)
		else $error("abort not reported");
	chk_align_code: assert property (@(posedge core_clk) disable iff (!rstn)
		msg_end && !hi_ev && msg_bits <= max_bits &&
		msg_bits > short_lim && !end_abort && bit_rem != 3'h0
		|-> code == hderr_pkg::HDERR_ALIGN)
		else $error("alignment error not reported");
	chk_fcs_code: assert property (@(posedge core_clk) disable iff (!rstn)
		msg_end && !hi_ev && msg_bits <= max_bits &&
		msg_bits > short_lim && !end_abort && bit_rem == 3'h0 &&
		end_flag && chk_bad
		|-> code == hderr_pkg::HDERR_CHK)
		else $error("checksum error not reported");
	chk_serr_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
		!serr_n && !hi_ev && !msg_end |-> code == hderr_pkg::HDERR_NONE)
		else $error("system error raised an event");
	////////////////////////////////////////////////////////////////////
	// internal descriptor queue
	logic [31:0] q_r [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0]   cnt_r;
	logic [AW-1:0] last_idx;
	logic          full, push, pop;
	assign full = cnt_r == (AW+1)'(DEPTH);
	assign push = code != hderr_pkg::HDERR_NONE;
	assign pop  = desc_valid && desc_ready;
	// newest entry still queued; the one on desc_data is already out
	assign last_idx = (wp_r == '0) ? AW'(DEPTH-1) : wp_r - 1'b1;
	// entry storage, one slot per generate pass
	for (genvar k = 0; k < DEPTH; k++) begin : g_entry
		always_ff @(posedge core_clk) begin
			if (push && !full && wp_r == AW'(k))
				q_r[k] <= {12'h000, code, 16'h0000};
			else if (push && full && last_idx == AW'(k))
				// only bit 15 is touched; code field kept
				q_r[k][`HDERR_LOST_BIT] <= 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			desc_valid <= 1'b0;
			desc_data <= 32'h0000_0000;
		end else begin
			// a full queue drops the new event
			if (push && !full) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (!desc_valid && cnt_r != '0) begin
				desc_valid <= 1'b1;
				desc_data <= q_r[rp_r];
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end else if (pop) begin
				desc_valid <= 1'b0;
			end
			cnt_r <= cnt_r + (AW+1)'(push && !full)
				- (AW+1)'(!desc_valid && cnt_r != '0);
		end
	end
	////////////////////////////////////////////////////////////////////
	// registers and interrupt
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stat_r <= 8'h00;
			mask_r <= 8'h00;
			ctrl_r <= 32'h0000_0000;
			thresh_r <= {24'h000000, `HDERR_THRESH_RST};
			reg_rdata <= 32'h0000_0000;
			irq <= 1'b0;
		end else begin
			// set wins over write-one-to-clear
			stat_r <= (stat_r & ~((reg_wr && reg_addr == `HDERR_REG_STATUS)
				? reg_wdata[7:0] : 8'h00)) | ev;
			if (reg_wr && reg_addr == `HDERR_REG_MASK)
				mask_r <= reg_wdata[7:0];
			if (reg_wr && reg_addr == `HDERR_REG_CTRL)
				ctrl_r <= {29'h0, reg_wdata[2:0]};
			if (reg_wr && reg_addr == `HDERR_REG_THRESH)
				thresh_r <= {24'h000000, reg_wdata[7:0]};
			irq <= |(stat_r & mask_r);
			reg_rdata <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					`HDERR_REG_STATUS: reg_rdata <= {24'h0, stat_r};
					`HDERR_REG_MASK:   reg_rdata <= {24'h0, mask_r};
					`HDERR_REG_CTRL:   reg_rdata <= ctrl_r;
					`HDERR_REG_THRESH: reg_rdata <= thresh_r;
					`HDERR_REG_QCOUNT: reg_rdata <= 32'(cnt_r);
					default:           reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	chk_align_no_chk: assert property (@(posedge core_clk) disable iff (!rstn)
		msg_end && bit_rem != 3'h0 |-> code != hderr_pkg::HDERR_CHK)
		else $error("checksum code raised with alignment error");
	chk_no_reserved: assert property (@(posedge core_clk) disable iff (!rstn)
		!(code inside {4'h5, 4'h6, 4'h7}))
		else $error("reserved error code emitted");
	chk_mem_protect_violation_block: assert property (@(posedge core_clk) disable iff (!rstn)
		mem_protect_violation_bad |=> !dma_go)
		else $error("protected access not blocked");
	chk_par_code: assert property (@(posedge core_clk) disable iff (!rstn)
		par_err_rx && par_resp_en |-> ev[7])
		else $error("parity error not reported");
	chk_par_mask: assert property (@(posedge core_clk) disable iff (!rstn)
		!par_resp_en |-> !ev[7])
		else $error("parity reported while response off");
	chk_long_drop: assert property (@(posedge core_clk) disable iff (!rstn)
		msg_end && msg_bits > max_bits |=> rx_drop)
		else $error("long message not dropped");
	chk_desc_fields: assert property (@(posedge core_clk) disable iff (!rstn)
		desc_valid |-> desc_data[31:20] == 12'h000 &&
		desc_data[14:0] == 15'h0000)
		else $error("descriptor field other than code or flag set");
	chk_desc_code: assert property (@(posedge core_clk) disable iff (!rstn)
		desc_valid |-> desc_data[19:16] != 4'h0)
		else $error("descriptor queued without an error code");
	chk_oof_code: assert property (@(posedge core_clk) disable iff (!rstn)
		oof_rise && ctrl_r[1] && !par_err_rx && !mem_protect_violation_bad
		|-> code == hderr_pkg::HDERR_OOF)
		else $error("out of frame not reported");
	chk_queue_bound: assert property (@(posedge core_clk) disable iff (!rstn)
		full && push |=> cnt_r <= (AW+1)'(DEPTH))
		else $error("queue overflowed");
endmodule

// ===== bench/hderr_host.sv
`timescale 1ns/10ps
// host side of the descriptor handshake; stalls at random or on hold
module hderr_host (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// stall control and handshake
	input  wire logic hold,
	output logic      desc_ready
);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			desc_ready <= 1'b0;
		else
			desc_ready <= !hold && ($urandom % 3 != 0);
	end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t value mismatch", $time); end end
module testbench;
	logic core_clk, rstn, reg_wr, reg_rd, dma_req, rx_frame_loss_input;
	logic msg_end, end_flag, end_abort, chk_bad, chk32, par_err_rx, serr_n;
	logic par_resp_en, desc_ready, hold, irq, dma_go, rx_drop, desc_valid;
	logic ab, ck, w;
	logic [2:0]  bit_rem, r;
	logic [3:0]  e;
	logic [7:0]  reg_addr, signal_unit_error_count;
	logic [14:0] msg_bits, max_bits, b;
	logic [31:0] reg_wdata, reg_rdata, dma_addr, mem_protect_violation_lo, mem_protect_violation_hi;
	logic [31:0] desc_data, got;
	int          error_cnt, checks, i, n;
	hderr_report u_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .irq, .dma_req, .dma_addr, .mem_protect_violation_lo, .mem_protect_violation_hi,
		.dma_go, .rx_frame_loss_input, .msg_end, .end_flag, .end_abort,
		.chk_bad, .bit_rem, .msg_bits, .max_bits, .chk32, .rx_drop,
		.signal_unit_error_count, .par_err_rx, .serr_n, .par_resp_en,
		.desc_valid, .desc_data, .desc_ready);
	hderr_host u_host (.core_clk, .rstn, .hold, .desc_ready);
	////////////////////////////////////////////////////////////////////////
	// message code by priority long, short, abort, align, checksum
	function automatic logic [3:0] mcode(input logic [14:0] bits);
		if (bits > max_bits) return 4'hC;
		if (bits <= (w ? 15'h20 : 15'h10)) return 4'hD;
		if (ab) return 4'hB;
		if (r != 3'h0) return 4'hA;
		if (ck) return 4'h9;
		return 4'h0;
	endfunction
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1;
	endtask
	// bounded wait for one accepted descriptor
	task automatic getd(input logic [3:0] c, input logic l);
		got = 32'h0;
		for (i = 0; i < 80 && got === 32'h0; i++) begin
			@(posedge core_clk);
			if (desc_valid === 1'b1 && desc_ready === 1'b1)
				got = desc_data;
		end
		`CHK(got[19:16], c)
		`CHK(got[15], l)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// watchdog fires after 20000 cycles, far above the whole run
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{rstn, reg_wr, reg_rd, dma_req, rx_frame_loss_input, msg_end} = '0;
		{end_flag, end_abort, chk_bad, chk32, par_err_rx, hold} = '0;
		{reg_addr, signal_unit_error_count, bit_rem, msg_bits} = '0;
		{reg_wdata, dma_addr, error_cnt, checks} = '0;
		{serr_n, par_resp_en, max_bits} = {2'h3, 15'h40};
		{mem_protect_violation_lo, mem_protect_violation_hi} = {32'h1000, 32'h1FFF};
		void'($urandom(32'h38c5e1c0));
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		bus(1'b1, 8'h04, 32'hFF);
		bus(1'b1, 8'h08, 32'h7);
		// first four are length boundaries, the rest random
		for (n = 0; n < 30; n++) begin
			ab = n > 3 && $urandom % 4 == 0;
			ck = n < 4 || $urandom % 2;
			r = (n == 2 || $urandom % 3 == 0) ? 3'h3 : 3'h0;
			w = n > 3 && $urandom % 2;
			b = n < 4 ? 15'h10 + n * 15'h18 : 15'($urandom_range(8, 80));
			e = mcode(b);
			@(posedge core_clk);
			{end_abort, end_flag, chk_bad, bit_rem} <= {ab, !ab, ck, r};
			{msg_bits, chk32, msg_end} <= {b, w, 1'b1};
			@(posedge core_clk);
			msg_end <= 1'b0;
			@(posedge core_clk);
			`CHK(rx_drop, e >= 4'hC)
			if (e != 4'h0) getd(e, 1'b0);
		end
		rx_frame_loss_input <= 1'b1;
		getd(4'h8, 1'b0);
		{rx_frame_loss_input, signal_unit_error_count} <= {1'b0, 8'h41};
		getd(4'hE, 1'b0);
		{serr_n, par_err_rx} <= 2'h1;
		@(posedge core_clk);
		par_err_rx <= 1'b0;
		getd(4'hF, 1'b0);
		{par_err_rx, par_resp_en, dma_req} <= 3'h1;
		dma_addr <= 32'h2000 + $urandom % 256;
		@(posedge core_clk);
		{par_err_rx, dma_req} <= 2'h2;
		@(posedge core_clk);
		par_err_rx <= 1'b0;
		`CHK(dma_go, 1'b0)
		getd(4'h4, 1'b0);
		{serr_n, dma_req, dma_addr} <= {2'h3, 32'h1000 + $urandom % 4096};
		@(posedge core_clk);
		dma_req <= 1'b0;
		@(posedge core_clk);
		`CHK(dma_go, 1'b1)
		// overflow while the host stalls; toggled so each pulse counts
		{hold, par_resp_en} <= 2'h3;
		for (n = 0; n < 24; n++)
			@(posedge core_clk) par_err_rx <= n % 2 == 0;
		hold <= 1'b0;
		n = 0;
		for (i = 0; i < 300; i++) begin
			@(posedge core_clk);
			if (desc_valid === 1'b1 && desc_ready === 1'b1)
				{n, got} = {n + 1, desc_data};
		end
		`CHK(got[15], 1'b1)
		`CHK(got[19:0], 20'hF8000)
		`CHK(n > 7 && n < 10, 1'b1)
		`CHK(irq, 1'b1)
		bus(1'b0, 8'h00, 32'h0);
		`CHK(reg_rdata[7:4], 4'hF)
		bus(1'b0, 8'h0C, 32'h0);
		`CHK(reg_rdata, 32'h40)
		bus(1'b0, 8'h10, 32'h0);
		`CHK(reg_rdata, 32'h0)
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h00, 32'hFF);
		`CHK(irq, 1'b0)
		bus(1'b0, 8'h00, 32'h0);
		`CHK(reg_rdata, 32'h0)
		tally_and_finish();
	end
endmodule
